// ==== fsrl_regs.sv ====
// address, reset control and receive lane map registers with strap capture
`timescale 1ns/1ps
`include "fsrl_consts.svh"

module fsrl_regs
  import fsrl_pkg::*;
#(
  parameter logic [7:0] PULSE_CYCLES = 8'(`FSRL_PULSE_CYCLES)
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clock_enable,
  input  wire logic [6:0] address_strap_pin,
  input  wire logic       mode_strap_pin_b,
  input  wire logic       second_port_bus_enable,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic      [6:0] own_bus_address,
  output logic      [6:0] second_port_bus_address,
  output logic            rx_dsi_reset,
  output logic            core_reset,
  output logic            rx_a_clock_polarity_swap,
  output logic            rx_a_data_polarity_swap,
  output logic            rx_a_lane_order_reverse,
  output logic            rx_b_clock_polarity_swap,
  output logic            rx_b_data_polarity_swap,
  output logic            rx_b_lane_order_reverse,
  output logic      [7:0] general_config
);

  fsrl_state_t q;
  fsrl_state_t next_q;
  logic        dsi_pulse_active;
  logic        core_pulse_active;
  logic        write_ok;
  logic        wr_address;
  logic        wr_reset;
  logic        wr_lane;
  logic        wr_general;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // pulse generators

  fsrl_pulse #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_dsi_pulse (
    .clock        (clock),
    .rst          (rst),
    .clock_enable (clock_enable),
    .trigger      (q.dsi_pulse_kick),
    .active       (dsi_pulse_active)
  );

  fsrl_pulse #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_core_pulse (
    .clock        (clock),
    .rst          (rst),
    .clock_enable (clock_enable),
    .trigger      (q.core_pulse_kick),
    .active       (core_pulse_active)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state

  assign write_ok   = reg_write && (q.phase == fsrl_run);
  assign wr_address = write_ok && hit(reg_addr, `FSRL_OFS_ADDRESS);
  assign wr_reset   = write_ok && hit(reg_addr, `FSRL_OFS_RESET);
  assign wr_lane    = write_ok && hit(reg_addr, `FSRL_OFS_LANE_MAP);
  assign wr_general = write_ok && hit(reg_addr, `FSRL_OFS_GENERAL);

  always_comb begin
    next_q = q;
    next_q.addr_pin_meta   = address_strap_pin;
    next_q.addr_pin_sync   = q.addr_pin_meta;
    next_q.mode_pin_meta   = mode_strap_pin_b;
    next_q.mode_pin_sync   = q.mode_pin_meta;
    next_q.dsi_pulse_kick  = 1'b0;
    next_q.core_pulse_kick = 1'b0;
    next_q.rvalid          = 1'b0;

    unique case (q.phase)
      fsrl_fill_first: begin
        next_q.phase = fsrl_fill_second;
      end
      fsrl_fill_second: begin
        next_q.phase = fsrl_load_strap;
      end
      fsrl_load_strap: begin
        next_q.phase       = fsrl_run;
        next_q.strap_addr  = q.addr_pin_sync;
        next_q.strap_mode  = q.mode_pin_sync;
        next_q.addr_field  = q.addr_pin_sync;
        next_q.dsi_disable = q.mode_pin_sync;
      end
      fsrl_run: begin
        if (wr_address) begin
          next_q.addr_field  = reg_wdata[`FSRL_ADDR_FIELD_MSB:`FSRL_ADDR_FIELD_LSB];
          next_q.addr_select = reg_wdata[`FSRL_ADDR_SELECT_BIT];
        end
        if (wr_lane) begin
          next_q.lane_map = reg_wdata & `FSRL_LANE_MAP_MASK;
        end
        if (wr_general) begin
          next_q.general = reg_wdata;
        end
        if (wr_reset) begin
          next_q.dsi_disable    = reg_wdata[`FSRL_RST_DSI_DISABLE];
          next_q.dsi_pulse_kick = reg_wdata[`FSRL_RST_DSI_PULSE];
          if (reg_wdata[`FSRL_RST_CORE_KEEP]) begin
            next_q.core_pulse_kick = 1'b1;
            next_q.addr_field      = q.strap_addr;
            next_q.dsi_disable     = q.strap_mode;
          end
          if (reg_wdata[`FSRL_RST_CORE_FULL]) begin
            next_q.core_pulse_kick = 1'b1;
            next_q.addr_field      = q.strap_addr;
            next_q.addr_select     = `FSRL_ADDR_SELECT_RST;
            next_q.dsi_disable     = q.strap_mode;
            next_q.lane_map        = `FSRL_LANE_MAP_RST;
            next_q.general         = `FSRL_GENERAL_RST;
          end
        end
      end
    endcase

    next_q.own_addr = q.addr_select ? q.addr_field : q.strap_addr;
    if (second_port_bus_enable) begin
      next_q.second_addr = 7'(next_q.own_addr + 7'h01);
    end else begin
      next_q.second_addr = next_q.own_addr;
    end
    next_q.dsi_reset  = q.dsi_disable || dsi_pulse_active || (q.phase != fsrl_run);
    next_q.core_reset = core_pulse_active;

    if (reg_read) begin
      next_q.rvalid = 1'b1;
      if (hit(reg_addr, `FSRL_OFS_ADDRESS)) begin
        next_q.rdata = {q.addr_field, q.addr_select};
      end else if (hit(reg_addr, `FSRL_OFS_RESET)) begin
        next_q.rdata = {4'h0, q.dsi_disable, 3'h0};
      end else if (hit(reg_addr, `FSRL_OFS_LANE_MAP)) begin
        next_q.rdata = q.lane_map;
      end else if (hit(reg_addr, `FSRL_OFS_GENERAL)) begin
        next_q.rdata = q.general;
      end else begin
        next_q.rdata = `FSRL_READ_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q             <= '0;
      q.phase       <= fsrl_fill_first;
      q.addr_select <= `FSRL_ADDR_SELECT_RST;
      q.lane_map    <= `FSRL_LANE_MAP_RST;
      q.general     <= `FSRL_GENERAL_RST;
      q.dsi_reset   <= 1'b1;
    end else if (clock_enable) begin
      q <= next_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata                = q.rdata;
  assign reg_rvalid               = q.rvalid;
  assign own_bus_address          = q.own_addr;
  assign second_port_bus_address  = q.second_addr;
  assign rx_dsi_reset             = q.dsi_reset;
  assign core_reset               = q.core_reset;
  assign rx_b_clock_polarity_swap = q.lane_map[`FSRL_LANE_B_CLK_SWAP];
  assign rx_b_data_polarity_swap  = q.lane_map[`FSRL_LANE_B_DATA_SWAP];
  assign rx_b_lane_order_reverse  = q.lane_map[`FSRL_LANE_B_REVERSE];
  assign rx_a_clock_polarity_swap = q.lane_map[`FSRL_LANE_A_CLK_SWAP];
  assign rx_a_data_polarity_swap  = q.lane_map[`FSRL_LANE_A_DATA_SWAP];
  assign rx_a_lane_order_reverse  = q.lane_map[`FSRL_LANE_A_REVERSE];
  assign general_config           = q.general;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking fsrl_cb @(posedge clock);
  endclocking
  default disable iff (rst);

  strap_load_a: assert property (
    (clock_enable && q.phase == fsrl_load_strap) |=> (q.addr_field == $past(q.addr_pin_sync)))
    else $error("address field did not load the strap address");

  second_addr_a: assert property (
    (clock_enable && second_port_bus_enable && q.phase == fsrl_run && !q.addr_select && !wr_reset)
      |=> (second_port_bus_address == 7'($past(q.strap_addr) + 7'h01)))
    else $error("second port address is not strap address plus one");

  addr_select_a: assert property (
    (clock_enable && q.phase == fsrl_run && q.addr_select)
      |=> (own_bus_address == $past(q.addr_field)))
    else $error("programmed address not used when selected");

  dsi_hold_a: assert property (
    (clock_enable && q.dsi_disable) |=> rx_dsi_reset)
    else $error("receiver left reset while disable bit set");

  dsi_pulse_a: assert property (
    (clock_enable && wr_reset && reg_wdata[`FSRL_RST_DSI_PULSE]) ##1 clock_enable [*3]
      |=> rx_dsi_reset)
    else $error("receiver reset pulse missing");

  full_reset_a: assert property (
    (clock_enable && wr_reset && reg_wdata[`FSRL_RST_CORE_FULL])
      |=> (general_config == `FSRL_GENERAL_RST && q.lane_map == `FSRL_LANE_MAP_RST && !q.addr_select))
    else $error("full core reset did not restore registers");

  keep_regs_a: assert property (
    (clock_enable && wr_reset && !reg_wdata[`FSRL_RST_CORE_FULL] && reg_wdata[`FSRL_RST_CORE_KEEP])
      |=> ($stable(q.lane_map) && $stable(q.general)) ##1 clock_enable [*3] ##1 core_reset)
    else $error("keep-registers reset lost registers or gave no pulse");

  strap_reload_a: assert property (
    (clock_enable && wr_reset && reg_wdata[`FSRL_RST_CORE_KEEP])
      |=> (q.addr_field == $past(q.strap_addr) && q.dsi_disable == $past(q.strap_mode)))
    else $error("strap registers not reloaded");

  lane_write_a: assert property (
    (clock_enable && wr_lane)
      |=> ({rx_b_clock_polarity_swap, rx_b_data_polarity_swap, rx_b_lane_order_reverse,
            rx_a_clock_polarity_swap, rx_a_data_polarity_swap, rx_a_lane_order_reverse}
           == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}))
    else $error("lane map outputs do not follow the write");

  reset_values_a: assert property (
    (q.phase == fsrl_fill_first) |-> (general_config == `FSRL_GENERAL_RST && q.lane_map == `FSRL_LANE_MAP_RST))
    else $error("wrong reset values");

  selfclear_read_a: assert property (
    (clock_enable && reg_read && hit(reg_addr, `FSRL_OFS_RESET))
      |=> (reg_rvalid && reg_rdata[7:4] == 4'h0 && reg_rdata[2:0] == 3'h0))
    else $error("self-clearing or reserved bits read as one");

  boot_dsi_hold_a: assert property (
    (clock_enable && q.phase != fsrl_run) |=> rx_dsi_reset)
    else $error("receiver released before strap load");

  core_pulse_a: assert property (
    (clock_enable && wr_reset && reg_wdata[`FSRL_RST_CORE_FULL]) ##1 clock_enable [*3]
      |=> core_reset)
    else $error("full core reset gave no pulse");

  lane_reserved_a: assert property (
    (clock_enable && reg_read && hit(reg_addr, `FSRL_OFS_LANE_MAP))
      |=> (reg_rvalid && reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0))
    else $error("reserved lane map bits read as one");

  unmapped_read_a: assert property (
    (clock_enable && reg_read && reg_addr > `FSRL_OFS_GENERAL)
      |=> (reg_rvalid && reg_rdata == `FSRL_READ_IDLE))
    else $error("unmapped offset did not read zero");

  second_off_a: assert property (
    (clock_enable && !second_port_bus_enable) |=> (second_port_bus_address == own_bus_address))
    else $error("second port address differs while its bus is off");

  strap_boot_c: cover property (q.phase == fsrl_load_strap ##1 q.phase == fsrl_run);
  select_prog_c: cover property (clock_enable && wr_address && reg_wdata[0]);
  dsi_pulse_c: cover property (clock_enable && wr_reset && reg_wdata[`FSRL_RST_DSI_PULSE]);
  keep_reset_c: cover property (clock_enable && wr_reset && reg_wdata[`FSRL_RST_CORE_KEEP]);
  full_reset_c: cover property (clock_enable && wr_reset && reg_wdata[`FSRL_RST_CORE_FULL]);

endmodule : fsrl_regs

// ==== fsrl_consts.svh ====
// register offsets, field positions, reset values and timing counts of the reset and lane map bank
`ifndef FSRL_CONSTS_SVH
`define FSRL_CONSTS_SVH

`define FSRL_OFS_ADDRESS      8'h00
`define FSRL_OFS_RESET        8'h01
`define FSRL_OFS_LANE_MAP     8'h02
`define FSRL_OFS_GENERAL      8'h03

`define FSRL_ADDR_FIELD_MSB   7
`define FSRL_ADDR_FIELD_LSB   1
`define FSRL_ADDR_SELECT_BIT  0

`define FSRL_RST_DSI_DISABLE  3
`define FSRL_RST_DSI_PULSE    2
`define FSRL_RST_CORE_FULL    1
`define FSRL_RST_CORE_KEEP    0

`define FSRL_LANE_B_CLK_SWAP  6
`define FSRL_LANE_B_DATA_SWAP 5
`define FSRL_LANE_B_REVERSE   4
`define FSRL_LANE_A_CLK_SWAP  2
`define FSRL_LANE_A_DATA_SWAP 1
`define FSRL_LANE_A_REVERSE   0
`define FSRL_LANE_MAP_MASK    8'h77

`define FSRL_LANE_MAP_RST     8'h00
`define FSRL_GENERAL_RST      8'h92
`define FSRL_ADDR_SELECT_RST  1'b0
`define FSRL_READ_IDLE        8'h00

`define FSRL_CLOCK_PERIOD_NS  10
`define FSRL_PULSE_NS         40
`define FSRL_PULSE_CYCLES     ((`FSRL_PULSE_NS + `FSRL_CLOCK_PERIOD_NS - 1) / `FSRL_CLOCK_PERIOD_NS)

`endif

// ==== fsrl_pkg.sv ====
// types of the reset and lane map bank
package fsrl_pkg;

  typedef enum logic [1:0] {
    fsrl_fill_first,
    fsrl_fill_second,
    fsrl_load_strap,
    fsrl_run
  } fsrl_phase_t;

  typedef struct packed {
    logic [7:0] count;
    logic       active;
  } fsrl_pulse_state_t;

  typedef struct packed {
    fsrl_phase_t phase;
    logic [6:0]  addr_pin_meta;
    logic [6:0]  addr_pin_sync;
    logic        mode_pin_meta;
    logic        mode_pin_sync;
    logic [6:0]  strap_addr;
    logic        strap_mode;
    logic [6:0]  addr_field;
    logic        addr_select;
    logic        dsi_disable;
    logic [7:0]  lane_map;
    logic [7:0]  general;
    logic [6:0]  own_addr;
    logic [6:0]  second_addr;
    logic        dsi_pulse_kick;
    logic        core_pulse_kick;
    logic        dsi_reset;
    logic        core_reset;
    logic [7:0]  rdata;
    logic        rvalid;
  } fsrl_state_t;

endpackage : fsrl_pkg

// ==== fsrl_pulse.sv ====
// fixed-length pulse generator for the self-clearing resets
`timescale 1ns/1ps
`include "fsrl_consts.svh"

module fsrl_pulse
  import fsrl_pkg::*;
#(
  parameter logic [7:0] PULSE_CYCLES = 8'(`FSRL_PULSE_CYCLES)
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clock_enable,
  input  wire logic trigger,
  output logic      active
);

  fsrl_pulse_state_t q;
  fsrl_pulse_state_t next_q;

  always_comb begin
    next_q = q;
    if (trigger) begin
      next_q.count  = PULSE_CYCLES;
      next_q.active = 1'b1;
    end else if (q.count > 8'h01) begin
      next_q.count  = q.count - 8'h01;
      next_q.active = 1'b1;
    end else begin
      next_q.count  = 8'h00;
      next_q.active = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (clock_enable) begin
      q <= next_q;
    end
  end

  assign active = q.active;

endmodule : fsrl_pulse

// ==== fsrl_host.sv ====
// host software model driving the register port of the bank
`timescale 1ns/1ps

module fsrl_host (
  input  wire logic       clock,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one byte write, gap plus one idle cycles first; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap + 1) @(posedge clock);
    #1;
    reg_write = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_write = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // one byte read; unknown returned when no answer came
  task automatic rd(input logic [7:0] a, input int gap, output logic [7:0] q);
    repeat (gap + 1) @(posedge clock);
    #1;
    reg_read = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    q        = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    reg_read = 1'b0;
    reg_addr = ~a;
  endtask : rd

  // programmed address always written with its lowest bit clear
  task automatic set_address(input logic [6:0] field, input logic sel, input int gap);
    wr(8'h00, {field[6:1], 1'b0, sel}, gap);
  endtask : set_address
endmodule : fsrl_host

// ==== testbench.sv ====
// self-checking bench for the reset and lane map register bank
`timescale 1ns/1ps
`include "fsrl_consts.svh"

module testbench;
  localparam int PULSE = 4;
  logic       clock, rst, clock_enable, mode_strap_pin_b, second_port_bus_enable;
  logic [6:0] address_strap_pin, own_bus_address, second_port_bus_address, strap0;
  logic       reg_write, reg_read, reg_rvalid, rx_dsi_reset, core_reset, mode0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, general_config, q, v, lanes;
  logic       a_clk, a_dat, a_rev, b_clk, b_dat, b_rev;
  int         num_errors = 0, num_checks = 0, seed = 60258, cycles = 0, n;

  assign lanes = {1'b0, b_clk, b_dat, b_rev, 1'b0, a_clk, a_dat, a_rev};

  fsrl_regs #(.PULSE_CYCLES(8'(PULSE))) uut (
    .clock(clock), .rst(rst), .clock_enable(clock_enable),
    .address_strap_pin(address_strap_pin), .mode_strap_pin_b(mode_strap_pin_b),
    .second_port_bus_enable(second_port_bus_enable), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .own_bus_address(own_bus_address),
    .second_port_bus_address(second_port_bus_address), .rx_dsi_reset(rx_dsi_reset),
    .core_reset(core_reset), .rx_a_clock_polarity_swap(a_clk),
    .rx_a_data_polarity_swap(a_dat), .rx_a_lane_order_reverse(a_rev),
    .rx_b_clock_polarity_swap(b_clk), .rx_b_data_polarity_swap(b_dat),
    .rx_b_lane_order_reverse(b_rev), .general_config(general_config));

  fsrl_host host (
    .clock(clock), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  // checking helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] second_exp(input logic [6:0] own, input logic en);
    return {1'b0, en ? own + 7'h01 : own};
  endfunction : second_exp

  function automatic logic [7:0] lane_exp(input logic [7:0] d);
    return d & `FSRL_LANE_MAP_MASK;
  endfunction : lane_exp

  // cycles that a reset output stays high after a write
  task automatic pulse_len(input bit dsi, output int cnt);
    cnt = 0;
    repeat (10) begin
      @(posedge clock);
      #1;
      if ((dsi ? rx_dsi_reset : core_reset) === 1'b1) cnt++;
    end
  endtask : pulse_len

  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst                    = 1'b1;
    clock_enable           = 1'b1;
    second_port_bus_enable = 1'b1;
    address_strap_pin      = 7'($random(seed));
    mode_strap_pin_b       = 1'($random(seed));
    strap0                 = address_strap_pin;
    mode0                  = mode_strap_pin_b;
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check({7'h00, rx_dsi_reset}, 8'h01);
    repeat (4) @(posedge clock);
    #1;
    check({1'b0, own_bus_address}, {1'b0, strap0});
    check({1'b0, second_port_bus_address}, second_exp(strap0, 1'b1));
    check(general_config, `FSRL_GENERAL_RST);
    check({7'h00, rx_dsi_reset}, {7'h00, mode0});
    host.rd(`FSRL_OFS_ADDRESS, 0, q);
    check(q, {strap0, 1'b0});
    host.rd(`FSRL_OFS_RESET, 1, q);
    check(q, {4'h0, mode0, 3'h0});
    host.rd(`FSRL_OFS_LANE_MAP, 0, q);
    check(q, 8'h00);
    host.rd(8'h3C, 2, q);
    check(q, 8'h00);
    // lane map corners then random values
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h88 : 8'($random(seed));
      host.wr(`FSRL_OFS_LANE_MAP, v, i % 3);
      check(lanes & 8'h40, v & 8'h40);
      check(lanes & 8'h20, v & 8'h20);
      check(lanes & 8'h10, v & 8'h10);
      check(lanes & 8'h04, v & 8'h04);
      check(lanes & 8'h02, v & 8'h02);
      check(lanes & 8'h01, v & 8'h01);
      host.rd(`FSRL_OFS_LANE_MAP, 0, q);
      check(q, lane_exp(v));
    end
    clock_enable = 1'b0;
    host.wr(`FSRL_OFS_LANE_MAP, ~v, 0);
    check(lanes, lane_exp(v));
    clock_enable = 1'b1;
    host.wr(8'hA5, 8'h00, 0);
    host.rd(`FSRL_OFS_LANE_MAP, 0, q);
    check(q, lane_exp(v));
    // programmed address with the second port on and off
    v = 8'($random(seed));
    host.set_address(v[7:1], 1'b1, 1);
    @(posedge clock);
    #1;
    check({1'b0, own_bus_address}, {1'b0, v[7:2], 1'b0});
    check({1'b0, second_port_bus_address}, second_exp({v[7:2], 1'b0}, 1'b1));
    second_port_bus_enable = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check({1'b0, second_port_bus_address}, {1'b0, own_bus_address});
    second_port_bus_enable = 1'b1;
    // sticky receiver disable, reserved bits ignored
    host.wr(`FSRL_OFS_RESET, 8'hF8, 0);
    @(posedge clock);
    #1;
    check({7'h00, rx_dsi_reset}, 8'h01);
    host.rd(`FSRL_OFS_RESET, 0, q);
    check(q, 8'h08);
    host.wr(`FSRL_OFS_RESET, 8'h00, 0);
    @(posedge clock);
    #1;
    check({7'h00, rx_dsi_reset}, 8'h00);
    host.wr(`FSRL_OFS_RESET, 8'h04, 0);
    pulse_len(1'b1, n);
    check(8'(n), 8'(PULSE));
    host.rd(`FSRL_OFS_RESET, 0, q);
    check(q, 8'h00);
    // keep-register core reset with the strap pins changed meanwhile
    address_strap_pin = ~strap0;
    mode_strap_pin_b  = ~mode0;
    v                 = 8'($random(seed));
    host.wr(`FSRL_OFS_GENERAL, v, 0);
    check(general_config, v);
    host.wr(`FSRL_OFS_RESET, 8'h01, 1);
    pulse_len(1'b0, n);
    check(8'(n), 8'(PULSE));
    host.rd(`FSRL_OFS_ADDRESS, 0, q);
    check(q, {strap0, 1'b1});
    check({7'h00, rx_dsi_reset}, {7'h00, mode0});
    check({1'b0, own_bus_address}, {1'b0, strap0});
    check(general_config, v);
    host.rd(`FSRL_OFS_RESET, 0, q);
    check(q, {4'h0, mode0, 3'h0});
    // full core reset restores defaults
    host.wr(`FSRL_OFS_RESET, 8'h02, 0);
    pulse_len(1'b0, n);
    check(8'(n), 8'(PULSE));
    host.rd(`FSRL_OFS_LANE_MAP, 0, q);
    check(q, 8'h00);
    host.rd(`FSRL_OFS_ADDRESS, 0, q);
    check(q, {strap0, 1'b0});
    check(general_config, `FSRL_GENERAL_RST);
    tally_and_finish();
  end
endmodule : testbench
